// [dv/sigma_delta_decimation_filter_checker.sv]
// port assertions for the decimation filter
`timescale 1ns/1ps
module sigma_delta_decimation_filter_checker (
  // clock and reset
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  // setup side
  input wire logic [3:0]                 filter_type_in,
  input wire logic                       setup_load_in,
  // result stream and status
  input wire logic [decim_pkg::RES_W-1:0] data_out,
  input wire logic                       data_valid_out,
  input wire logic                       data_ready_in,
  input wire logic                       overrun_out,
  input wire logic [3:0]                 active_type_out
);
  import decim_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // cycles since a restart with an empty stream, saturating
  logic [15:0] quiet_q;
  logic [15:0] quiet_d;

  // words in flight may still land in the first few cycles
  always_comb begin
    quiet_d = quiet_q;
    if (quiet_q != 16'hffff) quiet_d = quiet_q + 16'h0001;
    if (setup_load_in && !data_valid_out) quiet_d = 16'h0000;
    if (data_valid_out && quiet_q < 16'h0010) quiet_d = 16'hffff;
  end

  // register only; reset counts as a restart
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) quiet_q <= 16'h0000;
    else quiet_q <= quiet_d;
  end

  property p_reset_type;
    $rose(rst_n_in) |-> active_type_out == FT_RESET;
  endproperty
  a_reset_type: assert property (p_reset_type)
    else $error("type after reset wrong");
  property p_reset_idle;
    $rose(rst_n_in) |-> !data_valid_out && !overrun_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("stream not idle after reset");
  property p_load_type;
    setup_load_in && filter_type_in <= FT_POST4
      |=> active_type_out == $past(filter_type_in);
  endproperty
  a_load_type: assert property (p_load_type)
    else $error("loaded type not shown");
  property p_type_steady;
    !setup_load_in |=> $stable(active_type_out);
  endproperty
  a_type_steady: assert property (p_type_steady)
    else $error("type changed without load");
  property p_hold_word;
    data_valid_out && !data_ready_in |=> data_valid_out && $stable(data_out);
  endproperty
  a_hold_word: assert property (p_hold_word)
    else $error("word dropped before taken");
  property p_overrun_single;
    overrun_out |=> !overrun_out;
  endproperty
  a_overrun_single: assert property (p_overrun_single)
    else $error("overrun longer than a cycle");
  property p_overrun_full;
    overrun_out |-> $past(data_valid_out);
  endproperty
  a_overrun_full: assert property (p_overrun_full)
    else $error("overrun with empty output");
  property p_quiet;
    quiet_q >= 16'h0010 && quiet_q < 16'h5dc0 |-> !data_valid_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("result earlier than any filter allows");
endmodule

bind sigma_delta_decimation_filter sigma_delta_decimation_filter_checker
  u_checker (
  .clk_in          (clk_in),
  .rst_n_in        (rst_n_in),
  .filter_type_in  (filter_type_in),
  .setup_load_in   (setup_load_in),
  .data_out        (data_out),
  .data_valid_out  (data_valid_out),
  .data_ready_in   (data_ready_in),
  .overrun_out     (overrun_out),
  .active_type_out (active_type_out)
);

// [dv/test_sigma_delta_decimation_filter.sv]
// self-checking bench for the decimation filter and its fifo
`timescale 1ns/1ps
module test_sigma_delta_decimation_filter;
  import decim_pkg::*;
  // design stimulus and response
  logic        clk_in;
  logic        rst_n_in;
  logic        mod_bit_in;
  logic [3:0]  filter_type_in;
  logic [10:0] decimation_factor_in;
  logic        setup_load_in;
  logic [23:0] data_out;
  logic        data_valid_out;
  logic        data_ready_in;
  logic        overrun_out;
  logic [3:0]  active_type_out;
  // bookkeeping
  int          err_total;
  int          cmp_count;
  int          n;
  localparam int TK = MCLK_DIV;

  initial clk_in = 1'b0;
  always #25 clk_in = ~clk_in;

  sigma_delta_decimation_filter #(.FIFO_W(RES_W), .FIFO_D(FIFO_DEPTH))
    u_sigma_delta_decimation_filter (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .mod_bit_in(mod_bit_in),
    .filter_type_in(filter_type_in),
    .decimation_factor_in(decimation_factor_in),
    .setup_load_in(setup_load_in), .data_out(data_out),
    .data_valid_out(data_valid_out), .data_ready_in(data_ready_in),
    .overrun_out(overrun_out), .active_type_out(active_type_out));

  // compare one value, four-state exact
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare a cycle count against a window
  task chk_in(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // one-cycle setup pulse
  task load(input logic [3:0] t, input logic [10:0] f);
    @(negedge clk_in);
    filter_type_in = t;
    decimation_factor_in = f;
    setup_load_in = 1'b1;
    @(negedge clk_in);
    setup_load_in = 1'b0;
  endtask
  // bounded wait for a presented word
  task wait_word(input int limit, output int cnt);
    cnt = 0;
    while (data_valid_out !== 1'b1 && cnt < limit) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask
  // accept the presented word in one handshake
  task take;
    @(negedge clk_in);
    data_ready_in = 1'b1;
    @(negedge clk_in);
    data_ready_in = 1'b0;
  endtask

  // every documented code reaches the status port
  task test_decode;
    for (int c = 0; c <= 8; c++) begin
      load(4'(c), 11'h001);
      @(negedge clk_in);
      chk("active type", 32'(c), 32'(active_type_out));
    end
  endtask
  // sinc3 factor 1: three outputs to settle, then 32 ticks apart
  task test_sinc3;
    load(FT_SINC3, 11'h001);
    wait_word(30000, n);
    chk_in("sinc3 first", 95 * TK, 96 * TK + 16, n);
    // first word sits one lsb of the sinc gain below full scale
    chk("sinc3 first top", 32'h00007fff, 32'(data_out[23:8]));
    take();
    wait_word(9000, n);
    chk_in("sinc3 period", 32 * TK - 2, 32 * TK + 2, n + 2);
    chk("sinc3 word", 32'h007fffff, 32'(data_out));
  endtask
  // sinc4 factor 1: three outputs dropped, the fourth is the first word
  task test_sinc4;
    load(FT_SINC4, 11'h001);
    wait_word(36000, n);
    chk_in("sinc4 first", 127 * TK, 128 * TK + 16, n);
    chk("sinc4 first top", 32'h00007fff, 32'(data_out[23:8]));
    take();
  endtask
  // post filter ignores the factor, so no sinc-rate word appears
  task test_post;
    load(FT_POST1, 11'h001);
    wait_word(24990, n);
    chk("post early word", 32'h0, 32'(data_valid_out));
  endtask
  // sinc3 word left untaken: the next one queues behind it in the fifo
  task test_fifo;
    repeat (32 * TK + 8) @(negedge clk_in);
    chk("fifo hold valid", 32'h1, 32'(data_valid_out));
    chk("fifo hold word", 32'h007fffff, 32'(data_out));
    take();
    chk("fifo next valid", 32'h1, 32'(data_valid_out));
    chk("fifo next word", 32'h007fffff, 32'(data_out));
    take();
    chk("fifo empty", 32'h0, 32'(data_valid_out));
  endtask

  // single verdict point
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cut a hang short just past the planned run length
  initial begin
    repeat (100500) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  // main sequence
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    mod_bit_in = 1'b1;
    filter_type_in = FT_SINC3;
    decimation_factor_in = FS_RESET;
    setup_load_in = 1'b0;
    data_ready_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    chk("reset type", 32'(FT_RESET), 32'(active_type_out));
    chk("reset valid", 32'h0, 32'(data_valid_out));
    test_decode();
    test_sinc3();
    test_fifo();
    test_sinc4();
    test_post();
    end_of_test();
  end
endmodule

// [rtl/decim_pkg.sv]
// shared constants and types for the sigma-delta decimation filter
package decim_pkg;

  // clocking: system clock and the modulator (main) clock rate
  localparam int unsigned CLK_HZ   = 20000000;   // system clock, 50 ns
  localparam int unsigned MCLK_HZ  = 76800;      // modulator bit rate
  // cycles per modulator tick, rounded down (260)
  localparam int unsigned MCLK_DIV = CLK_HZ / MCLK_HZ;
  localparam int unsigned DIV_W    = 9;

  // filter type codes of the per-setup selection field
  localparam logic [3:0] FT_SINC4      = 4'h0;
  localparam logic [3:0] FT_SINC4_AVG  = 4'h1;
  localparam logic [3:0] FT_SINC3      = 4'h2;
  localparam logic [3:0] FT_SINC3_N60  = 4'h3;
  localparam logic [3:0] FT_SINC3_AVG  = 4'h4;
  localparam logic [3:0] FT_POST1      = 4'h5;
  localparam logic [3:0] FT_POST2      = 4'h6;
  localparam logic [3:0] FT_POST3      = 4'h7;
  localparam logic [3:0] FT_POST4      = 4'h8;
  localparam logic [3:0] FT_RESET      = FT_SINC3;  // value after reset

  // decimation factor limits and reset value
  localparam logic [10:0] FS_MIN       = 11'h001;
  localparam logic [10:0] FS_SINC4_MAX = 11'h00a;   // decimal ten
  localparam logic [10:0] FS_RESET     = 11'h001;

  // sinc stage decimates by this many ticks per unit of factor
  localparam int unsigned TICKS_PER_FS = 32;
  localparam int unsigned AVG_LEN      = 8;          // sinc1 averaging
  localparam int unsigned AVG_SHIFT    = 3;          // log2 of AVG_LEN

  // post filter conversion times in main clock cycles
  localparam int unsigned PF1_TCNV = 2944;
  localparam int unsigned PF2_TCNV = 3200;
  localparam int unsigned PF3_TCNV = 3968;
  localparam int unsigned PF4_TCNV = 4736;
  // post filters run sinc3 at factor 1 and average a power-of-two window
  localparam int unsigned PF_SUM   = 64;
  localparam int unsigned PF_SHIFT = 6;
  localparam int unsigned PF1_LEN  = PF1_TCNV / TICKS_PER_FS;   // 92
  localparam int unsigned PF2_LEN  = PF2_TCNV / TICKS_PER_FS;   // 100
  localparam int unsigned PF3_LEN  = PF3_TCNV / TICKS_PER_FS;   // 124
  localparam int unsigned PF4_LEN  = PF4_TCNV / TICKS_PER_FS;   // 148

  // datapath widths
  localparam int unsigned ACC_W    = 52;   // cic integrators
  localparam int unsigned SUM_W    = 60;   // averaging accumulator
  localparam int unsigned RES_W    = 24;   // result word
  localparam int unsigned CNT_W    = 8;    // sinc outputs per result
  localparam int unsigned DEC_W    = 16;   // ticks per sinc output
  localparam int unsigned FIFO_DEPTH = 16;

  // result word scaling: full-scale lands on bit RES_W-1
  localparam int unsigned RES_TOP  = RES_W - 1;

  // result phase: discard settling outputs, then accumulate
  typedef enum logic [0:0] {
    PH_SKIP = 1'b0,
    PH_SUM  = 1'b1
  } phase_type;

endpackage

// [rtl/result_fifo.sv]
// result fifo with registered output stage
`timescale 1ns/1ps
module result_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];    // storage array
  logic [AW-1:0]    wr_q, wr_d;       // write pointer
  logic [AW-1:0]    rd_q, rd_d;       // read pointer
  logic [AW:0]      cnt_q, cnt_d;     // words held in the array
  logic             ov_q, ov_d;       // output register valid
  logic [WIDTH-1:0] od_q, od_d;       // output register data
  logic             push, pop;

  // next-state: output register refills whenever it empties
  always_comb begin
    push = in_valid_in && (cnt_q != DEPTH[AW:0]);
    pop  = (cnt_q != '0) && (!ov_q || out_ready_in);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ov_d = pop ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rd_q] : od_q;
  end

  // registers; array has no reset, it is guarded by the count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  // array write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // full only counts the array; the output register is extra slack
  assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = ov_q;
  assign out_data_out  = od_q;
endmodule

// [rtl/sigma_delta_decimation_filter.sv]
// sinc3/sinc4 decimation chain with averaging and post filter modes
// What this block does
// - filter type resets to plain sinc3
// - decode four-bit filter type field
// - sinc4 factor clamps to one..ten
// - sinc3 factor uses eleven-bit value, zero taken as one
// - sinc decimates by thirty-two times factor
// - averaging adds sinc1 over eight results
// - averaging first conversion equals later ones
// - post filters ignore decimation factor
// - post filters give fixed output rates
// - conversion time 32, 352, 320 times factor
// - post filter times 2944/3200/3968/4736 cycles
`timescale 1ns/1ps
module sigma_delta_decimation_filter
  import decim_pkg::*;
#(
  parameter int unsigned FIFO_W = decim_pkg::RES_W,
  parameter int unsigned FIFO_D = decim_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  // modulator bit stream from the pin
  input  wire logic                         mod_bit_in,
  // setup selection, taken on setup_load_in
  input  wire logic [3:0]                   filter_type_in,
  input  wire logic [10:0]                  decimation_factor_in,
  input  wire logic                         setup_load_in,
  // result stream
  output logic [decim_pkg::RES_W-1:0]       data_out,
  output logic                              data_valid_out,
  input  wire logic                         data_ready_in,
  // status
  output logic                              overrun_out,
  output logic [3:0]                        active_type_out
);
  import decim_pkg::*;

  // pin synchroniser
  logic              bit_meta_q;      // first stage, read only by next
  logic              bit_q;           // safe modulator bit

  // main clock divider
  logic [DIV_W-1:0]  div_q, div_d;
  logic              tick_q, tick_d;  // one-cycle main clock enable

  // latched setup
  logic [3:0]        type_q, type_d;
  logic [10:0]       fs_q, fs_d;

  // cic state
  logic [ACC_W-1:0]  integ_q [4];
  logic [ACC_W-1:0]  integ_d [4];
  logic [ACC_W-1:0]  dly_q [4];       // comb delay taps
  logic [ACC_W-1:0]  dly_d [4];
  logic [DEC_W-1:0]  dec_q, dec_d;    // ticks inside a sinc output

  // result assembly
  phase_type         ph_q, ph_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [SUM_W-1:0]  sum_q, sum_d;
  logic              first_q, first_d; // plain sinc still settling
  logic              pend_q, pend_d;   // result waiting for the fifo
  logic [RES_W-1:0]  res_q, res_d;
  logic              ovr_q, ovr_d;

  // decoded setup
  logic              order4;          // sinc4 rather than sinc3
  logic              is_avg;
  logic              is_post;
  logic [10:0]       fs_eff;
  logic [DEC_W-1:0]  ratio;           // ticks per sinc output
  logic [CNT_W-1:0]  skip_n;
  logic [CNT_W-1:0]  sum_n;
  logic [5:0]        shift_n;         // normalising shift
  logic              fifo_ready;

  // ceiling log2 of the decimation ratio, for the cic gain
  function automatic logic [4:0] clog2_16(input logic [DEC_W-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < DEC_W; i++) begin
      if ((DEC_W'(1) << i) < v) begin
        r = 5'(i + 1);
      end
    end
    return r;
  endfunction

  // two flip-flops before anything reads the modulator bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_meta_q <= 1'b0;
      bit_q      <= 1'b0;
    end else begin
      bit_meta_q <= mod_bit_in;
      bit_q      <= bit_meta_q;
    end
  end

  // divider: 20 MHz down to the main clock enable
  always_comb begin
    tick_d = (div_q == DIV_W'(MCLK_DIV - 1));
    div_d  = tick_d ? '0 : div_q + 1'b1;
  end

  // divider registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // decode the latched setup into order, ratio and frame shape
  always_comb begin
    order4  = 1'b0;
    is_avg  = 1'b0;
    is_post = 1'b0;
    fs_eff  = (fs_q < FS_MIN) ? FS_MIN : fs_q;
    skip_n  = '0;
    sum_n   = CNT_W'(1);
    case (type_q)
      FT_SINC4: begin
        order4 = 1'b1;
      end
      FT_SINC4_AVG: begin
        order4 = 1'b1;
        is_avg = 1'b1;
      end
      FT_SINC3_AVG: begin
        is_avg = 1'b1;
      end
      FT_POST1, FT_POST2, FT_POST3, FT_POST4: begin
        is_post = 1'b1;
      end
      // sinc3, sinc3 with extra notch, and reserved codes run sinc3
      default: begin
        order4 = 1'b0;
      end
    endcase
    // sinc4 factor above ten is forced to ten
    if (order4 && fs_eff > FS_SINC4_MAX) begin
      fs_eff = FS_SINC4_MAX;
    end
    // post filters run the sinc3 at factor one, setup factor unused
    if (is_post) begin
      fs_eff = FS_MIN;
    end
    ratio = DEC_W'({fs_eff, 5'h00});
    if (is_avg) begin
      // flush order-1 outputs then average eight: 11 or 10 outputs
      skip_n = order4 ? CNT_W'(3) : CNT_W'(2);
      sum_n  = CNT_W'(AVG_LEN);
    end else if (is_post) begin
      sum_n = CNT_W'(PF_SUM);
      case (type_q)
        FT_POST1: skip_n = CNT_W'(PF1_LEN - PF_SUM);
        FT_POST2: skip_n = CNT_W'(PF2_LEN - PF_SUM);
        FT_POST3: skip_n = CNT_W'(PF3_LEN - PF_SUM);
        default:  skip_n = CNT_W'(PF4_LEN - PF_SUM);
      endcase
    end else if (first_q) begin
      // plain sinc only waits for settling after a restart
      skip_n = order4 ? CNT_W'(3) : CNT_W'(2);
    end
    shift_n = 6'({1'b0, clog2_16(ratio)} * (order4 ? 6'd4 : 6'd3));
    if (is_avg) begin
      shift_n = shift_n + 6'(AVG_SHIFT);
    end else if (is_post) begin
      shift_n = shift_n + 6'(PF_SHIFT);
    end
  end

  // filter datapath next state
  always_comb begin
    logic [ACC_W-1:0] x;
    logic [ACC_W-1:0] stage;
    logic [SUM_W-1:0] acc;
    logic [SUM_W-1:0] norm;
    logic             emit;
    x      = '0;
    stage  = '0;
    acc    = '0;
    norm   = '0;
    emit   = 1'b0;
    type_d  = type_q;
    fs_d    = fs_q;
    dec_d   = dec_q;
    ph_d    = ph_q;
    cnt_d   = cnt_q;
    sum_d   = sum_q;
    first_d = first_q;
    res_d   = res_q;
    for (int k = 0; k < 4; k++) begin
      integ_d[k] = integ_q[k];
      dly_d[k]   = dly_q[k];
    end
    if (setup_load_in) begin
      // new setup restarts the chain, as for a new channel
      type_d  = filter_type_in;
      fs_d    = decimation_factor_in;
      dec_d   = '0;
      ph_d    = PH_SKIP;
      cnt_d   = '0;
      sum_d   = '0;
      first_d = 1'b1;
      for (int k = 0; k < 4; k++) begin
        integ_d[k] = '0;
        dly_d[k]   = '0;
      end
    end else if (tick_q) begin
      // modulator bit as +1 / -1
      x = bit_q ? ACC_W'(1) : {ACC_W{1'b1}};
      integ_d[0] = integ_q[0] + x;
      for (int k = 1; k < 4; k++) begin
        integ_d[k] = integ_q[k] + integ_q[k-1];
      end
      if (dec_q == ratio - 1'b1) begin
        dec_d = '0;
        // comb chain; the fourth stage passes through for sinc3
        stage = order4 ? integ_q[3] : integ_q[2];
        for (int k = 0; k < 4; k++) begin
          dly_d[k] = stage;
          if (k < 3 || order4) begin
            stage = stage - dly_q[k];
          end
        end
        if (ph_q == PH_SKIP) begin
          // settling outputs are dropped so every result is settled
          if (cnt_q + 1'b1 >= skip_n) begin
            ph_d  = PH_SUM;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else begin
          acc   = sum_q + {{(SUM_W-ACC_W){stage[ACC_W-1]}}, stage};
          if (cnt_q == sum_n - 1'b1) begin
            emit    = 1'b1;
            first_d = 1'b0;
            sum_d   = '0;
            cnt_d   = '0;
            ph_d    = (is_avg || is_post) ? PH_SKIP : PH_SUM;
          end else begin
            sum_d = acc;
            cnt_d = cnt_q + 1'b1;
          end
        end
      end else begin
        dec_d = dec_q + 1'b1;
      end
    end
    // scale so that full scale sits on the top result bit
    if (shift_n >= 6'(RES_TOP)) begin
      norm = $signed(acc) >>> (shift_n - 6'(RES_TOP));
    end else begin
      norm = acc << (6'(RES_TOP) - shift_n);
    end
    // saturate: an all-ones stream would otherwise wrap to negative
    if ($signed(norm) > $signed(SUM_W'((1 << RES_TOP) - 1))) begin
      norm = SUM_W'((1 << RES_TOP) - 1);
    end else if ($signed(norm) < -$signed(SUM_W'(1 << RES_TOP))) begin
      norm = -SUM_W'(1 << RES_TOP);
    end
    if (emit) begin
      res_d = norm[RES_W-1:0];
    end
    // newest result wins; a displaced one is reported as overrun
    pend_d = emit ? 1'b1 : (fifo_ready ? 1'b0 : pend_q);
    ovr_d  = emit && pend_q && !fifo_ready;
  end

  // filter datapath registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      type_q  <= FT_RESET;
      fs_q    <= FS_RESET;
      dec_q   <= '0;
      ph_q    <= PH_SKIP;
      cnt_q   <= '0;
      sum_q   <= '0;
      first_q <= 1'b1;
      pend_q  <= 1'b0;
      res_q   <= '0;
      ovr_q   <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        integ_q[k] <= '0;
        dly_q[k]   <= '0;
      end
    end else begin
      type_q  <= type_d;
      fs_q    <= fs_d;
      dec_q   <= dec_d;
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
      sum_q   <= sum_d;
      first_q <= first_d;
      pend_q  <= pend_d;
      res_q   <= res_d;
      ovr_q   <= ovr_d;
      for (int k = 0; k < 4; k++) begin
        integ_q[k] <= integ_d[k];
        dly_q[k]   <= dly_d[k];
      end
    end
  end

  // results queue here; a stalled reader fills it and then holds pend
  result_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (pend_q),
    .in_data_in    (res_q),
    .in_ready_out  (fifo_ready),
    .out_valid_out (data_valid_out),
    .out_data_out  (data_out),
    .out_ready_in  (data_ready_in)
  );

  // status outputs straight from registers
  assign overrun_out     = ovr_q;
  assign active_type_out = type_q;
endmodule
